// file: rtl/mxce_channel.sv
/*
 Multiplex channel: takes one subchannel request at a time, runs interlace
 update and data move or a memory increment over the secondary memory port.
 Assumes the port completes each access in the cycle it is issued.
*/
`timescale 1ns/1ps
module mxce_channel
	import mxce_pkg::*;
(
	input  wire logic                  i_clock,     // 200 MHz memory cycle clock
	input  wire logic                  i_rst_n,     // Synchronous reset, active low
	mxce_if.chan                       bus,         // Subchannel bus
	input  wire logic                  i_cpu_req,   // Processor wants this memory
	output logic                       o_cpu_stall, // Processor held this cycle
	output logic                       o_mem_en,    // Memory access strobe
	output logic                       o_mem_we,    // Write when high
	output logic [mxce_pkg::ADDR_W-1:0] o_mem_addr, // Memory address
	output logic [mxce_pkg::WORD_W-1:0] o_mem_wdata, // Write word
	output logic                       o_mem_wpar,  // Write parity
	input  wire logic [mxce_pkg::WORD_W-1:0] i_mem_rdata, // Read word
	input  wire logic                  i_mem_rpar   // Read parity
);
	import mxce_pkg::*;

	typedef enum {
		MXCE_IDLE,
		MXCE_IL_READ,
		MXCE_IL_RESTORE,
		MXCE_DATA,
		MXCE_INC_READ,
		MXCE_INC_WRITE,
		MXCE_ANSWER
	} mxce_state_e;

	mxce_state_e        state_reg;
	logic [WORD_W-1:0]  work_reg;
	logic [ADDR_W-1:0]  addr_reg;
	logic               zero_reg;
	logic               perr_reg;
	logic               inc_gap_reg;
	logic [WORD_W-1:0]  ilw_next;
	logic [WORD_W-1:0]  inc_next;
	logic               bus_par_ok;
	logic               take_ok;

	assign bus_par_ok = (mxce_parity(bus.wdata) == bus.wpar);
	// A request still shown beside done is the one just answered
	assign take_ok = bus.sel_valid && !bus.done;

	// Interlace update: address up, count down; zero count wraps to 511
	always_comb
	begin
		ilw_next = i_mem_rdata;
		ilw_next[ILW_ADDR_MSB:ILW_ADDR_LSB] = i_mem_rdata[ILW_ADDR_MSB:ILW_ADDR_LSB] + 15'h0001;
		ilw_next[ILW_COUNT_MSB:ILW_COUNT_LSB] = i_mem_rdata[ILW_COUNT_MSB:ILW_COUNT_LSB] - 9'h001;
	end

	always_comb
	begin
		inc_next = i_mem_rdata;
		case (bus.inc_mode)
			MXCE_INC_FULL:  inc_next = i_mem_rdata + 24'h000001;
			MXCE_INC_UPPER: inc_next[WORD_W-1:HALF_W] = i_mem_rdata[WORD_W-1:HALF_W] + 12'h001;
			MXCE_INC_LOWER: inc_next[HALF_W-1:0] = i_mem_rdata[HALF_W-1:0] + 12'h001;
			default:        inc_next = i_mem_rdata;
		endcase
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			state_reg <= MXCE_IDLE;
		else
			case (state_reg)
				MXCE_IDLE:
					if (take_ok && bus.op == MXCE_OP_INC && !inc_gap_reg)
						state_reg <= MXCE_INC_READ;
					else if (take_ok && bus.op != MXCE_OP_INC)
						state_reg <= MXCE_IL_READ;
				MXCE_IL_READ:    state_reg <= MXCE_IL_RESTORE;
				MXCE_IL_RESTORE: state_reg <= MXCE_DATA;
				MXCE_DATA:       state_reg <= MXCE_ANSWER;
				MXCE_INC_READ:   state_reg <= MXCE_INC_WRITE;
				MXCE_INC_WRITE:  state_reg <= MXCE_ANSWER;
				MXCE_ANSWER:     state_reg <= MXCE_IDLE;
				default:         state_reg <= MXCE_IDLE;
			endcase
	end

	// Increments are two memory cycles each; the gap flag is high only in MXCE_ANSWER,
	// so it never holds back an increment that follows in MXCE_IDLE
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			inc_gap_reg <= 1'b0;
		else
			inc_gap_reg <= (state_reg == MXCE_INC_WRITE);
	end

	// The single working register holds interlace, data or increment word
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			work_reg <= 24'h000000;
			addr_reg <= 15'h0000;
			zero_reg <= 1'b0;
			perr_reg <= 1'b0;
		end
		else
			case (state_reg)
				MXCE_IDLE:
				begin
					addr_reg <= bus.addr;
					zero_reg <= 1'b0;
					perr_reg <= 1'b0;
				end
				MXCE_IL_READ:
				begin
					work_reg <= ilw_next;
					zero_reg <= (ilw_next[ILW_COUNT_MSB:ILW_COUNT_LSB] == 9'h000);
					perr_reg <= (mxce_parity(i_mem_rdata) != i_mem_rpar);
				end
				MXCE_IL_RESTORE:
					work_reg <= bus.wdata;
				MXCE_DATA:
					if (bus.op == MXCE_OP_READ)
					begin
						work_reg <= i_mem_rdata;
						perr_reg <= perr_reg | (mxce_parity(i_mem_rdata) != i_mem_rpar);
					end
					else
						perr_reg <= perr_reg | !bus_par_ok;
				MXCE_INC_READ:
				begin
					work_reg <= inc_next;
					zero_reg <= (inc_next == 24'h000000);
					perr_reg <= (mxce_parity(i_mem_rdata) != i_mem_rpar);
				end
				default:
					work_reg <= work_reg;
			endcase
	end

	// Memory port: driven only in the cycles that really transfer
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_mem_en    <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_addr  <= 15'h0000;
			o_mem_wdata <= 24'h000000;
			o_mem_wpar  <= 1'b0;
			o_cpu_stall <= 1'b0;
		end
		else
		begin
			o_mem_en    <= 1'b0;
			o_mem_we    <= 1'b0;
			o_mem_wdata <= 24'h000000;
			o_mem_wpar  <= 1'b0;
			o_cpu_stall <= 1'b0;
			// Secondary path owns the memory; processor loses only those cycles
			case (state_reg)
				MXCE_IDLE:
					if (take_ok && (bus.op != MXCE_OP_INC || !inc_gap_reg))
					begin
						o_mem_en    <= 1'b1;
						o_cpu_stall <= i_cpu_req;
						o_mem_addr  <= bus.addr;
					end
				MXCE_IL_READ, MXCE_INC_READ:
				begin
					o_mem_en    <= 1'b1;
					o_cpu_stall <= i_cpu_req;
					o_mem_we    <= 1'b1;
					o_mem_addr  <= addr_reg;
					o_mem_wdata <= (state_reg == MXCE_IL_READ) ? ilw_next : inc_next;
					o_mem_wpar  <= mxce_parity((state_reg == MXCE_IL_READ) ? ilw_next : inc_next);
				end
				MXCE_IL_RESTORE:
				begin
					o_mem_en    <= 1'b1;
					o_cpu_stall <= i_cpu_req;
					o_mem_we    <= (bus.op == MXCE_OP_WRITE);
					o_mem_addr  <= work_reg[ILW_ADDR_MSB:ILW_ADDR_LSB];
					o_mem_wdata <= bus.wdata;
					o_mem_wpar  <= mxce_parity(bus.wdata);
				end
				default:
					o_mem_addr <= o_mem_addr;
			endcase
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			bus.done    <= 1'b0;
			bus.zero    <= 1'b0;
			bus.rdata   <= 24'h000000;
			bus.rpar    <= 1'b0;
			bus.par_err <= 1'b0;
		end
		else
		begin
			bus.done    <= (state_reg == MXCE_ANSWER);
			bus.zero    <= (state_reg == MXCE_ANSWER) && zero_reg;
			bus.rdata   <= work_reg;
			bus.rpar    <= mxce_parity(work_reg);
			bus.par_err <= (state_reg == MXCE_ANSWER) && perr_reg;
		end
	end
endmodule

// file: rtl/mxce_subch.sv
/*
 Group of up to 128 data subchannels: fixed priority bus access, even/odd
 interlace sequencing, cycling, end of transfer and interrupt requests.
 Assumes the channel answers each request with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module mxce_subch
	import mxce_pkg::*;
(
	input  wire logic                        i_clock,    // 200 MHz clock
	input  wire logic                        i_rst_n,    // Synchronous reset, active low
	mxce_if.subch                            bus,        // Channel bus
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_start,   // Pulse: start subchannel
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_start_odd, // With start: begin on odd word
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_cycle,   // Return odd to even
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_dir_in,  // Device to memory when high
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_xfer,    // Device word ready
	input  wire logic [mxce_pkg::SUBCH_N-1:0] i_inc,     // Increment request
	input  wire logic [mxce_pkg::ADDR_W-1:0] i_inc_addr, // Increment address
	input  wire logic [1:0]                  i_inc_mode, // Increment width
	input  wire logic [mxce_pkg::WORD_W-1:0] i_wdata,    // Device word to memory
	output logic [mxce_pkg::SUBCH_N-1:0]     o_active,   // Subchannel running
	output logic [mxce_pkg::SUBCH_N-1:0]     o_irq,      // Interrupt request pulses
	output logic [mxce_pkg::WORD_W-1:0]      o_rdata,    // Word from memory
	output logic [mxce_pkg::SUBCH_N-1:0]     o_rvalid    // Pulse: o_rdata for subchannel
);
	import mxce_pkg::*;

	logic [SUBCH_N-1:0] active_reg;
	logic [SUBCH_N-1:0] odd_reg;
	logic [SUBCH_N-1:0] pend_reg;
	logic [SUBCH_N-1:0] incp_reg;
	logic               busy_reg;
	logic [SUBCH_W-1:0] owner_reg;
	logic               own_inc_reg;
	logic [SUBCH_W-1:0] pick;
	logic               pick_ok;
	logic               pick_inc;

	// Lowest number wins the bus
	always_comb
	begin
		pick = '0;
		pick_ok = 1'b0;
		pick_inc = 1'b0;
		for (int i = SUBCH_N - 1; i >= 0; i--)
			if (pend_reg[i] || incp_reg[i])
			begin
				pick = SUBCH_W'(i);
				pick_ok = 1'b1;
				pick_inc = incp_reg[i];
			end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			pend_reg <= '0;
			incp_reg <= '0;
		end
		else
		begin
			pend_reg <= pend_reg | (i_xfer & active_reg);
			incp_reg <= incp_reg | i_inc;
			// A new request in the answering cycle survives the clear
			if (bus.done && !own_inc_reg)
				pend_reg[owner_reg] <= i_xfer[owner_reg] & active_reg[owner_reg];
			if (bus.done && own_inc_reg)
				incp_reg[owner_reg] <= i_inc[owner_reg];
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			busy_reg    <= 1'b0;
			owner_reg   <= '0;
			own_inc_reg <= 1'b0;
			bus.sel_valid <= 1'b0;
			bus.sel     <= '0;
			bus.op      <= MXCE_OP_READ;
			bus.inc_mode <= MXCE_INC_FULL;
			bus.addr    <= '0;
			bus.wdata   <= '0;
			bus.wpar    <= 1'b0;
		end
		else if (!busy_reg && pick_ok)
		begin
			busy_reg    <= 1'b1;
			owner_reg   <= pick;
			own_inc_reg <= pick_inc;
			bus.sel_valid <= 1'b1;
			bus.sel     <= pick;
			bus.op      <= pick_inc ? MXCE_OP_INC : (i_dir_in[pick] ? MXCE_OP_WRITE : MXCE_OP_READ);
			bus.inc_mode <= mxce_inc_e'(i_inc_mode);
			// Interlace pair address for transfers, increment address for increments; never the data address
			bus.addr    <= pick_inc ? i_inc_addr : ILW_BASE + {7'h00, pick, odd_reg[pick]};
			bus.wdata   <= i_wdata;
			bus.wpar    <= mxce_parity(i_wdata);
		end
		else if (bus.done)
		begin
			busy_reg    <= 1'b0;
			bus.sel_valid <= 1'b0;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			active_reg <= '0;
			odd_reg    <= '0;
			o_irq      <= '0;
			o_rdata    <= '0;
			o_rvalid   <= '0;
		end
		else
		begin
			o_irq    <= '0;
			o_rvalid <= '0;
			if (bus.done)
			begin
				o_rdata <= bus.rdata;
				o_rvalid[owner_reg] <= !own_inc_reg && bus.op == MXCE_OP_READ;
				o_irq[owner_reg] <= bus.zero;
				if (bus.zero && !own_inc_reg)
				begin
					if (!odd_reg[owner_reg])
						odd_reg[owner_reg] <= 1'b1;
					else if (i_cycle[owner_reg])
						odd_reg[owner_reg] <= 1'b0;
					else
						active_reg[owner_reg] <= 1'b0;
				end
			end
			// A fresh start outranks the ending of the previous run
			for (int i = 0; i < SUBCH_N; i++)
				if (i_start[i])
				begin
					active_reg[i] <= 1'b1;
					odd_reg[i]    <= i_start_odd[i];
				end
		end
	end

	assign o_active = active_reg;
	assign bus.req = pend_reg;
	assign bus.inc_req = incp_reg;
endmodule

// file: shared/mxce_if.sv
/*
 Carrier between the multiplex channel and the data subchannel group.
 Assumes both ends share i_clock; requests are levels held until granted.
*/
`timescale 1ns/1ps
interface mxce_if;
	import mxce_pkg::*;
	logic [SUBCH_N-1:0] req;        // Per subchannel transfer request
	logic [SUBCH_N-1:0] inc_req;    // Per subchannel increment line
	logic [SUBCH_W-1:0] sel;        // Subchannel presenting on the bus
	logic               sel_valid;  // Bus holds a request
	mxce_op_e           op;         // Requested operation
	mxce_inc_e          inc_mode;   // Increment width
	logic [ADDR_W-1:0]  addr;       // Interlace word or increment address
	logic [WORD_W-1:0]  wdata;      // Data to memory
	logic               wpar;       // Parity of wdata
	logic               done;       // Pulse: operation finished
	logic               zero;       // With done: count or word became zero
	logic [WORD_W-1:0]  rdata;      // Data from memory with done
	logic               rpar;       // Parity of rdata
	logic               par_err;    // With done: parity fault seen
	modport chan (input req, inc_req, sel, sel_valid, op, inc_mode, addr, wdata, wpar,
		output done, zero, rdata, rpar, par_err);
	modport subch (output req, inc_req, sel, sel_valid, op, inc_mode, addr, wdata, wpar,
		input done, zero, rdata, rpar, par_err);
endinterface

// file: shared/mxce_pkg.sv
/*
 Package for the multiplexed channel interlace engine: word layout, operation
 codes, memory port and subchannel bus constants shared by both ends.
 Assumes a single 200 MHz clock and one memory cycle per clock on the port.
*/
package mxce_pkg;
	localparam int WORD_W      = 24;
	localparam int HALF_W      = 12;
	localparam int ADDR_W      = 15;
	localparam int COUNT_W     = 9;
	localparam int SUBCH_N     = 128;
	localparam int SUBCH_W     = 7;
	// Interlace word: count in MSB-numbered bits 0..8, address in bits 9..23
	localparam int ILW_COUNT_MSB = 23;
	localparam int ILW_COUNT_LSB = 15;
	localparam int ILW_ADDR_MSB  = 14;
	localparam int ILW_ADDR_LSB  = 0;
	// Pair base: subchannel n owns words at base + 2n and base + 2n + 1
	localparam logic [ADDR_W-1:0] ILW_BASE = 15'h0000;
	localparam int INC_GAP_CYCLES = 2;
	localparam logic [1:0] INC_RESET = 2'h0;

	typedef enum logic [1:0] {
		MXCE_OP_READ,
		MXCE_OP_WRITE,
		MXCE_OP_INC
	} mxce_op_e;

	typedef enum logic [1:0] {
		MXCE_INC_FULL,
		MXCE_INC_UPPER,
		MXCE_INC_LOWER
	} mxce_inc_e;

	function automatic logic mxce_parity(input logic [WORD_W-1:0] w);
		mxce_parity = ~(^w);
	endfunction
endpackage

// file: tb/mxce_checker.sv
/*
 Checker for the channel side: subchannel bus and memory port timing.
 Assumes instantiation beside the interface in the bench top.
*/
`timescale 1ns/1ps
module mxce_checker
	import mxce_pkg::*;
(
	input wire logic                         i_clock,     // Clock
	input wire logic                         i_rst_n,     // Reset, active low
	input wire logic [mxce_pkg::SUBCH_N-1:0] req,         // Pending requests
	input wire logic [mxce_pkg::SUBCH_N-1:0] inc_req,     // Pending increments
	input wire logic                         sel_valid,   // Request on bus
	input mxce_pkg::mxce_op_e                op,          // Operation
	input wire logic [mxce_pkg::ADDR_W-1:0]  addr,        // Request address
	input wire logic                         done,        // Finished
	input wire logic                         zero,        // Zero result
	input wire logic                         i_cpu_req,   // Processor request
	input wire logic                         o_cpu_stall, // Processor stall
	input wire logic                         o_mem_en,    // Memory strobe
	input wire logic                         o_mem_we,    // Memory write
	input wire logic [mxce_pkg::ADDR_W-1:0]  o_mem_addr,  // Memory address
	input wire logic [mxce_pkg::WORD_W-1:0]  o_mem_wdata, // Write word
	input wire logic                         o_mem_wpar   // Write parity
);
	logic [COUNT_W-1:0] wr_count;

	assign wr_count = o_mem_wdata[ILW_COUNT_MSB:ILW_COUNT_LSB];

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	property p_ilw_done;
		$rose(sel_valid) && op != MXCE_OP_INC |-> ##5 done;
	endproperty
	a_ilw_done: assert property (p_ilw_done)
		else $error("interlaced word not done in five cycles");
	property p_walk;
		$rose(sel_valid) && op != MXCE_OP_INC |-> ##1 (o_mem_en && !o_mem_we && o_mem_addr == addr)
			##1 (o_mem_en && o_mem_we && o_mem_addr == addr) ##1 o_mem_en ##1 !o_mem_en;
	endproperty
	a_walk: assert property (p_walk)
		else $error("interlace read, restore, data order broken");
	property p_inc_done;
		$rose(sel_valid) && op == MXCE_OP_INC |-> ##[4:5] done;
	endproperty
	a_inc_done: assert property (p_inc_done)
		else $error("increment not done in time");
	property p_mem_idle;
		o_mem_en |-> sel_valid;
	endproperty
	a_mem_idle: assert property (p_mem_idle)
		else $error("memory accessed outside a transfer");
	property p_wpar;
		o_mem_en && o_mem_we |-> o_mem_wpar == ~(^o_mem_wdata);
	endproperty
	a_wpar: assert property (p_wpar)
		else $error("write parity wrong");
	property p_zero;
		done && op != MXCE_OP_INC |-> zero == ($past(wr_count, 3) == '0);
	endproperty
	a_zero: assert property (p_zero)
		else $error("zero flag disagrees with restored count");
	property p_stall;
		o_cpu_stall |-> sel_valid || $past(sel_valid);
	endproperty
	a_stall: assert property (p_stall)
		else $error("processor stalled without secondary access");
	property p_stall_cycle;
		o_cpu_stall == (o_mem_en && $past(i_cpu_req));
	endproperty
	a_stall_cycle: assert property (p_stall_cycle)
		else $error("processor stall not matched to a secondary memory cycle");
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");
	property p_reset;
		$rose(i_rst_n) |-> req == '0 && inc_req == '0 && !sel_valid;
	endproperty
	a_reset: assert property (p_reset)
		else $error("requests survive reset");
endmodule

// file: tb/test_multiplexed_channel_interlace_engine.sv
/*
 Bench joining channel and subchannel group through the carrier.
 Assumes a combinational memory model sampled at the next edge.
*/
`timescale 1ns/1ps
module test_multiplexed_channel_interlace_engine;
	import mxce_pkg::*;
	logic                i_clock, i_rst_n, i_cpu_req, o_cpu_stall, i_mem_rpar;
	logic                o_mem_en, o_mem_we, o_mem_wpar, bad_par, perr, stalled;
	logic [SUBCH_N-1:0]  i_start, i_start_odd, i_cycle, i_dir_in, i_xfer, i_inc;
	logic [SUBCH_N-1:0]  o_active, o_irq, o_rvalid, seen_irq, first_rv;
	logic [ADDR_W-1:0]   i_inc_addr, o_mem_addr;
	logic [1:0]          i_inc_mode;
	logic [WORD_W-1:0]   i_wdata, o_rdata, o_mem_wdata, i_mem_rdata, got;
	logic [WORD_W-1:0]   mem [0:32767];
	int                  fail_count, checked, ndone;

	mxce_if bus_if();
	mxce_channel mxce_channel_i(.i_clock, .i_rst_n, .bus(bus_if), .i_cpu_req, .o_cpu_stall, .o_mem_en,
		.o_mem_we, .o_mem_addr, .o_mem_wdata, .o_mem_wpar, .i_mem_rdata, .i_mem_rpar);
	mxce_subch mxce_subch_i(.i_clock, .i_rst_n, .bus(bus_if), .i_start, .i_start_odd, .i_cycle,
		.i_dir_in, .i_xfer, .i_inc, .i_inc_addr, .i_inc_mode, .i_wdata, .o_active, .o_irq, .o_rdata,
		.o_rvalid);
	mxce_checker mxce_checker_i(.i_clock, .i_rst_n, .req(bus_if.req), .inc_req(bus_if.inc_req),
		.sel_valid(bus_if.sel_valid), .op(bus_if.op), .addr(bus_if.addr), .done(bus_if.done),
		.zero(bus_if.zero), .i_cpu_req, .o_cpu_stall, .o_mem_en, .o_mem_we, .o_mem_addr,
		.o_mem_wdata, .o_mem_wpar);

	assign i_mem_rdata = mem[o_mem_addr];
	// Odd parity; bad_par injects a fault
	assign i_mem_rpar = ~(^i_mem_rdata) ^ bad_par;
	always @(posedge i_clock)
		if (o_mem_en && o_mem_we)
			mem[o_mem_addr] <= o_mem_wdata;

	initial
	begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	function automatic logic [23:0] ilw(input logic [8:0] c, input logic [14:0] a);
		return {c, a};
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic do_reset(input int n);
		@(posedge i_clock);
		i_rst_n <= 1'b0;
		repeat (n) @(posedge i_clock);
		i_rst_n <= 1'b1;
		#1;
	endtask

	task automatic start_sub(input int n, input logic odd, input logic cyc, input logic din);
		@(posedge i_clock);
		i_start[n] <= 1'b1;
		i_start_odd[n] <= odd;
		i_cycle[n] <= cyc;
		i_dir_in[n] <= din;
		@(posedge i_clock);
		i_start[n] <= 1'b0;
	endtask

	// Pulses requests, then watches a window long enough for two operations
	task automatic go(input logic [127:0] x, input logic [127:0] ic, input logic [23:0] wd);
		@(posedge i_clock);
		i_xfer <= x;
		i_inc <= ic;
		i_wdata <= wd;
		@(posedge i_clock);
		i_xfer <= '0;
		i_inc <= '0;
		seen_irq = '0;
		first_rv = '0;
		ndone = 0;
		perr = 1'b0;
		stalled = 1'b0;
		repeat (30)
		begin
			@(posedge i_clock);
			#1;
			seen_irq |= o_irq;
			ndone += int'(bus_if.done === 1'b1);
			perr |= bus_if.done & bus_if.par_err;
			stalled |= o_cpu_stall;
			if (o_rvalid != '0 && first_rv == '0)
			begin
				first_rv = o_rvalid;
				got = o_rdata;
			end
		end
	endtask

	task automatic s_out_prio;
		mem[0] = ilw(9'h2, 15'h0100);
		mem[1] = ilw(9'h1, 15'h0200);
		mem[10] = ilw(9'h5, 15'h0300);
		mem[15'h0101] = 24'ha5a5a5;
		mem[15'h0102] = 24'h5a5a5a;
		mem[15'h0201] = 24'h123456;
		mem[15'h0301] = 24'h0f0f0f;
		start_sub(0, 1'b0, 1'b0, 1'b0);
		start_sub(5, 1'b0, 1'b0, 1'b0);
		go(128'h21, '0, '0);
		check("first served", first_rv[7:0], 8'h01);
		check("done count", ndone, 2);
		check("data", got, 24'ha5a5a5);
		check("even word", mem[0], ilw(9'h1, 15'h0101));
		check("stall", stalled, 1'b1);
		check("clean parity", perr, 1'b0);
		check("pair word", mem[10], ilw(9'h4, 15'h0301));
		go(128'h1, '0, '0);
		check("data", got, 24'h5a5a5a);
		check("even irq", seen_irq[0], 1'b1);
		check("to odd", o_active[0], 1'b1);
		go(128'h1, '0, '0);
		check("odd data", got, 24'h123456);
		check("odd word", mem[1], ilw(9'h0, 15'h0201));
		check("odd irq", seen_irq[0], 1'b1);
		check("irq lines", seen_irq[31:0], 32'h00000001);
		check("ended", o_active[0], 1'b0);
	endtask

	task automatic s_in_cycle;
		mem[3] = ilw(9'h1, 15'h0400);
		mem[2] = ilw(9'h0, 15'h0500);
		start_sub(1, 1'b1, 1'b1, 1'b1);
		go(128'h2, '0, 24'h3c3c3c);
		check("stored", mem[15'h0401], 24'h3c3c3c);
		check("odd word", mem[3], ilw(9'h0, 15'h0401));
		check("odd irq", seen_irq[1], 1'b1);
		check("cycled", o_active[1], 1'b1);
		go(128'h2, '0, 24'hc3c3c3);
		check("stored", mem[15'h0501], 24'hc3c3c3);
		check("full block", mem[2], ilw(9'h1ff, 15'h0501));
		check("no irq", seen_irq[1], 1'b0);
		check("word parity", perr, 1'b0);
		do_reset(2);
		check("idle", o_active != '0, 1'b0);
	endtask

	task automatic s_inc;
		logic [23:0] init_v [5] = '{24'h000fff, 24'h123456, 24'h123fff, 24'hffffff, 24'h000fff};
		logic [1:0]  mode_v [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
		logic [23:0] exp_v [5]  = '{24'h001000, 24'h124456, 24'h123000, 24'h000000, 24'h000000};
		for (int i = 0; i < 5; i++)
		begin
			mem[15'h0600] = init_v[i];
			@(posedge i_clock);
			i_inc_addr <= 15'h0600;
			i_inc_mode <= mode_v[i];
			go('0, 128'h80, '0);
			check("inc word", mem[15'h0600], exp_v[i]);
			check("inc zero irq", seen_irq[7], exp_v[i] == '0);
		end
		mem[15'h0600] = 24'h000010;
		@(posedge i_clock);
		i_inc_mode <= 2'h0;
		go('0, 128'h180, '0);
		check("two incs", mem[15'h0600], 24'h000012);
		check("inc done count", ndone, 2);
	endtask

	task automatic s_par;
		mem[8] = ilw(9'h3, 15'h0700);
		mem[15'h0701] = 24'h0f0f0f;
		@(posedge i_clock);
		bad_par <= 1'b1;
		i_cpu_req <= 1'b0;
		start_sub(4, 1'b0, 1'b0, 1'b0);
		go(128'h10, '0, '0);
		check("parity fault", perr, 1'b1);
		check("no stall for idle processor", stalled, 1'b0);
		bad_par <= 1'b0;
		i_cpu_req <= 1'b1;
		do_reset(2);
	endtask

	initial
	begin
		{i_start, i_start_odd, i_cycle, i_dir_in, i_xfer, i_inc} = '0;
		{i_inc_addr, i_inc_mode, i_wdata} = '0;
		i_rst_n = 1'b0;
		i_cpu_req = 1'b1;
		bad_par = 1'b0;
		fail_count = 0;
		checked = 0;
		repeat (6) @(posedge i_clock);
		i_rst_n <= 1'b1;
		s_out_prio();
		s_in_cycle();
		s_inc();
		s_par();
		end_of_test();
	end

	initial
	begin
		repeat (20000) @(posedge i_clock);
		fail_count++;
		end_of_test();
	end
endmodule
